// >>> fspa_pkg.sv
/*
  Constants shared by both ends of the flash self-programming sequencer:
  address geometry, control-register bit layout, timing counts and the
  controller's register map.
  Assumes a single 20 MHz clock and a 15-bit flash word address.
*/
// Overview of operation
// - boot fuse pair selects boot section start
// - 0x0000-0x6FFF blocked, 0x7000-0x7FFF stays readable
// - flash word address is fifteen bits wide
// - page holds 128 words, word bits 6:0
// - page number comes from pointer bits 15:8
// - pointer bits 7:1 pick slot; zero for write
// - pointer bit 0 zero; byte select for loads
// - during erase/write only readable region answers
// - erase or write command acts on store
// - enable alone loads data word into buffer
// - busy flag blocks reads until re-enable issued
// - poll enable bit clear before next command
// - wait for EEPROM write busy clear first
// - control write and store stay uninterrupted
// - store must follow within four cycles
// - busy flag holds while region busy or blocked
package fspa_pkg;

  localparam int PC_W = 15;
  localparam int PC_TOP = 14;
  localparam int PAGE_WORDS = 128;
  localparam int WORD_W = 7;
  localparam int PAGE_W = 8;
  localparam int PTR_W = 16;
  localparam int PTR_PAGE_LO = 8;
  localparam int PTR_PAGE_HI = 15;
  localparam int PTR_WORD_LO = 1;
  localparam int PTR_WORD_HI = 7;
  localparam int PTR_BYTE_SEL = 0;

  localparam logic [PC_W-1:0] BLOCKED_END = 15'h6fff;
  localparam logic [PC_W-1:0] READABLE_START = 15'h7000;
  localparam int BLOCKED_PAGES = 224;
  localparam int READABLE_PAGES = 32;

  localparam logic [PC_W-1:0] BOOT_START_512 = 15'h7e00;
  localparam logic [PC_W-1:0] BOOT_START_1K = 15'h7c00;
  localparam logic [PC_W-1:0] BOOT_START_2K = 15'h7800;
  localparam logic [PC_W-1:0] BOOT_START_4K = 15'h7000;

  // control register bit positions
  localparam int CTL_EN = 0;
  localparam int CTL_ERASE = 1;
  localparam int CTL_WRITE = 2;
  localparam int CTL_REEN = 4;
  localparam int CTL_BUSY = 6;
  localparam logic [7:0] CTL_RESET = 8'h00;

  localparam int WIN_CYCLES = 4;
  localparam int CLK_MHZ = 20;
  localparam int OP_TIME_US = 3700;
  localparam int OP_CYCLES = OP_TIME_US * CLK_MHZ;

  // controller registers, byte addresses
  localparam logic [7:0] REG_CMD = 8'h00;
  localparam logic [7:0] REG_PTR = 8'h04;
  localparam logic [7:0] REG_DATA = 8'h08;
  localparam logic [7:0] REG_STATUS = 8'h0c;
  localparam logic [7:0] REG_MASK = 8'h10;
  localparam logic [7:0] REG_RDADDR = 8'h14;
  localparam logic [7:0] REG_RDDATA = 8'h18;
  localparam logic [7:0] REG_BOOT = 8'h1c;

  localparam int ST_DONE = 0;
  localparam int ST_REFUSED = 1;
  localparam int ST_RDDONE = 2;
  localparam int ST_W = 3;

endpackage : fspa_pkg

// >>> fspa_if.sv
/*
  Link between the boot-loader controller and the sequencer.
  Assumes both ends share clk_i; all signals are synchronous to it.
*/
`timescale 1ns/10ps
interface fspa_if;
  import fspa_pkg::*;
  logic ctl_wr;
  logic [7:0] ctl_wdata;
  logic [7:0] ctl_rdata;
  logic store;
  logic [PTR_W-1:0] ptr;
  logic [15:0] data_word;
  logic ee_busy;
  logic rd_en;
  logic [PC_W-1:0] rd_addr;
  logic rd_valid;
  logic rd_blocked;
  logic [15:0] rd_data;
  logic [PC_W-1:0] boot_start;

  modport dev (
    input ctl_wr, ctl_wdata, store, ptr, data_word, rd_en, rd_addr,
    output ctl_rdata, ee_busy, rd_valid, rd_blocked, rd_data, boot_start
  );
  modport host (
    output ctl_wr, ctl_wdata, store, ptr, data_word, rd_en, rd_addr,
    input ctl_rdata, ee_busy, rd_valid, rd_blocked, rd_data, boot_start
  );
endinterface : fspa_if

// >>> fspa_dev.sv
/*
  Flash self-programming sequencer, device end: control register, timed
  store window, temporary page buffer, page erase/write toward the array
  and read gating of the blocked region.
  Assumes the flash array answers fl_rdata_i combinationally to
  fl_raddr_o and accepts one word per cycle while fl_wr_o is high.
*/
`timescale 1ns/10ps
module fspa_dev #(
  parameter int unsigned OP_CYCLES = fspa_pkg::OP_CYCLES
) (
  input wire logic clk_i,
  input wire logic rst_i,
  fspa_if.dev link,
  input wire logic [1:0] boot_size_i,
  input wire logic ee_busy_i,
  output logic fl_erase_o,
  output logic fl_wr_o,
  output logic [fspa_pkg::PAGE_W-1:0] fl_page_o,
  output logic [fspa_pkg::WORD_W-1:0] fl_word_o,
  output logic [15:0] fl_wdata_o,
  output logic [fspa_pkg::PC_W-1:0] fl_raddr_o,
  input wire logic [15:0] fl_rdata_i
);
  import fspa_pkg::*;

  typedef enum logic [2:0] {
    D_IDLE,
    D_ARMED,
    D_PROG,
    D_WAIT
  } fspa_dstate_t;

  fspa_dstate_t st;
  logic [7:0] cmd;
  logic busy_flag;
  logic [2:0] win;
  logic [WORD_W-1:0] idx;
  logic [16:0] tmr;
  logic [PAGE_W-1:0] page;
  logic [15:0] page_buf [PAGE_WORDS];

  ////////////////////////////////////////////////////////////////////////
  // address fields

  wire [PAGE_W-1:0] ptr_page = link.ptr[PTR_PAGE_HI:PTR_PAGE_LO];
  wire [WORD_W-1:0] ptr_word = link.ptr[PTR_WORD_HI:PTR_WORD_LO];
  wire ptr_odd = link.ptr[PTR_BYTE_SEL];
  wire [PC_W-1:0] boot_start_sel =
    (boot_size_i == 2'h3) ? BOOT_START_512 :
    (boot_size_i == 2'h2) ? BOOT_START_1K :
    (boot_size_i == 2'h1) ? BOOT_START_2K : BOOT_START_4K;

  ////////////////////////////////////////////////////////////////////////
  // command decode

  // an eeprom write in progress locks the control register out
  wire ctl_take = link.ctl_wr && !ee_busy_i && (st == D_IDLE || st == D_ARMED);
  // store with an odd pointer is dropped like a late one
  wire store_ok = (st == D_ARMED) && link.store && !ptr_odd;
  wire do_erase = store_ok && cmd[CTL_ERASE];
  wire do_write = store_ok && !cmd[CTL_ERASE] && cmd[CTL_WRITE];
  wire do_reen = store_ok && !cmd[CTL_ERASE] && !cmd[CTL_WRITE] && cmd[CTL_REEN];
  wire do_fill = store_ok && !cmd[CTL_ERASE] && !cmd[CTL_WRITE] && !cmd[CTL_REEN];
  wire win_expire = (st == D_ARMED) && !store_ok && (win == 3'h1);
  wire prog_last = (st == D_PROG) && (idx == WORD_W'(PAGE_WORDS - 1));
  wire op_done = (st == D_WAIT) && (tmr == 17'h00000);
  wire ctl_clear = do_reen || do_fill || win_expire || op_done;
  wire [7:0] next_cmd = ctl_take ? (link.ctl_wdata[CTL_EN] ? link.ctl_wdata : CTL_RESET) :
    ctl_clear ? CTL_RESET : cmd;
  // readback shows the flag as it will stand, so busy never lags an erase or write start
  wire next_busy = (do_erase || do_write) ? 1'b1 : do_reen ? 1'b0 : busy_flag;
  logic [7:0] next_view;

  always_comb begin
    next_view = next_cmd;
    next_view[CTL_BUSY] = next_busy;
  end

  ////////////////////////////////////////////////////////////////////////
  // sequencer state

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st <= D_IDLE;
    end else if (ctl_take) begin
      st <= link.ctl_wdata[CTL_EN] ? D_ARMED : D_IDLE;
    end else if (do_erase) begin
      st <= D_WAIT;
    end else if (do_write) begin
      st <= D_PROG;
    end else if (do_reen || do_fill || win_expire) begin
      st <= D_IDLE;
    end else if (prog_last) begin
      st <= D_WAIT;
    end else if (op_done) begin
      st <= D_IDLE;
    end
  end

  // control bits; enable stays high until the operation ends
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cmd <= CTL_RESET;
    end else if (ctl_take) begin
      cmd <= link.ctl_wdata[CTL_EN] ? link.ctl_wdata : CTL_RESET;
    end else if (do_reen || do_fill || win_expire || op_done) begin
      cmd <= CTL_RESET;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      win <= 3'h0;
    end else if (ctl_take) begin
      win <= 3'(WIN_CYCLES);
    end else if (st == D_ARMED && win != 3'h0) begin
      win <= win - 3'h1;
    end
  end

  // set on erase/write start, cleared only by a re-enable when idle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      busy_flag <= 1'b0;
    end else if (do_erase || do_write) begin
      busy_flag <= 1'b1;
    end else if (do_reen) begin
      busy_flag <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // temporary page buffer

  always_ff @(posedge clk_i) begin
    if (do_fill) begin
      page_buf[ptr_word] <= link.data_word;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // flash array side

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      page <= '0;
    end else if (do_erase || do_write) begin
      page <= ptr_page;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      fl_erase_o <= 1'b0;
    end else begin
      fl_erase_o <= do_erase;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      idx <= '0;
    end else if (do_write) begin
      idx <= '0;
    end else if (st == D_PROG) begin
      idx <= idx + WORD_W'(1);
    end
  end

  // one buffered word per cycle into the selected page
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      fl_wr_o <= 1'b0;
      fl_word_o <= '0;
      fl_wdata_o <= 16'h0000;
    end else begin
      fl_wr_o <= (st == D_PROG);
      fl_word_o <= idx;
      fl_wdata_o <= page_buf[idx];
    end
  end

  // erase/write busy time, counted after the page is handed over
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tmr <= 17'h00000;
    end else if (do_erase || prog_last) begin
      tmr <= 17'(OP_CYCLES - 1);
    end else if (st == D_WAIT && tmr != 17'h00000) begin
      tmr <= tmr - 17'h00001;
    end
  end

  assign fl_page_o = page;

  ////////////////////////////////////////////////////////////////////////
  // reads and fetches

  // blocked region gives no data while busy, readable region always does
  wire rd_in_blocked = (link.rd_addr <= BLOCKED_END);
  wire rd_refuse = rd_in_blocked && busy_flag;

  assign fl_raddr_o = link.rd_addr;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      link.rd_valid <= 1'b0;
      link.rd_blocked <= 1'b0;
      link.rd_data <= 16'h0000;
    end else begin
      link.rd_valid <= link.rd_en;
      if (link.rd_en) begin
        link.rd_blocked <= rd_refuse;
        link.rd_data <= rd_refuse ? 16'h0000 : fl_rdata_i;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // status toward the controller

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      link.ctl_rdata <= CTL_RESET;
      link.ee_busy <= 1'b0;
      link.boot_start <= BOOT_START_4K;
    end else begin
      link.ctl_rdata <= next_view;
      link.ee_busy <= ee_busy_i;
      link.boot_start <= boot_start_sel;
    end
  end

endmodule : fspa_dev

// >>> fspa_host.sv
/*
  Boot-loader controller end: a classic Wishbone slave whose registers
  order the sequencer's command handshake and flash reads, with a
  sticky status register, a mask and one level interrupt.
  Assumes a single-cycle Wishbone master on the same clock.
*/
`timescale 1ns/10ps
module fspa_host (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [3:0] wb_sel_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic irq_o,
  fspa_if.host link
);
  import fspa_pkg::*;

  typedef enum logic [2:0] {
    H_IDLE,
    H_POLL,
    H_EE,
    H_CTL,
    H_STORE,
    H_DONE,
    H_CHECK
  } fspa_hstate_t;

  fspa_hstate_t st;
  logic [7:0] cmd_val;
  logic [15:0] ptr;
  logic [15:0] data;
  logic [ST_W-1:0] status;
  logic [ST_W-1:0] mask;
  logic [PC_W-1:0] rd_addr;
  logic rd_go;
  logic [15:0] rd_res;
  logic rd_blk;

  ////////////////////////////////////////////////////////////////////////
  // bus decode

  wire req = wb_cyc_i && wb_stb_i;
  wire wr_fire = req && wb_we_i && wb_ack_o;
  wire wr_cmd = wr_fire && wb_adr_i == REG_CMD && wb_sel_i[0];
  wire wr_ptr = wr_fire && wb_adr_i == REG_PTR;
  wire wr_data = wr_fire && wb_adr_i == REG_DATA;
  wire wr_stat = wr_fire && wb_adr_i == REG_STATUS && wb_sel_i[0];
  wire wr_mask = wr_fire && wb_adr_i == REG_MASK && wb_sel_i[0];
  wire wr_rda = wr_fire && wb_adr_i == REG_RDADDR;
  wire [15:0] wmask = {{8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
  wire [15:0] wd = wb_dat_i[15:0];
  wire [7:0] nc = wb_dat_i[7:0];
  wire bad_cmd = nc[CTL_EN] && (ptr[PTR_BYTE_SEL] ||
    (nc[CTL_WRITE] && ptr[PTR_WORD_HI:PTR_WORD_LO] != 7'h00));
  wire start = wr_cmd && st == H_IDLE && !bad_cmd;
  wire refuse = wr_cmd && (st != H_IDLE || bad_cmd);
  wire dev_en = link.ctl_rdata[CTL_EN];
  wire done_ev = st == H_CHECK && !(cmd_val[CTL_REEN] && link.ctl_rdata[CTL_BUSY]);
  wire [ST_W-1:0] ev = {link.rd_valid, refuse, done_ev};
  wire [31:0] rd_mux =
    (wb_adr_i == REG_CMD) ? {23'h0, st != H_IDLE, link.ctl_rdata} :
    (wb_adr_i == REG_PTR) ? {16'h0, ptr} :
    (wb_adr_i == REG_DATA) ? {16'h0, data} :
    (wb_adr_i == REG_STATUS) ? {29'h0, status} :
    (wb_adr_i == REG_MASK) ? {29'h0, mask} :
    (wb_adr_i == REG_RDADDR) ? {17'h0, rd_addr} :
    (wb_adr_i == REG_RDDATA) ? {15'h0, rd_blk, rd_res} :
    (wb_adr_i == REG_BOOT) ? {17'h0, link.boot_start} : 32'h0;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0;
    end else begin
      wb_ack_o <= req && !wb_ack_o;
      if (req && !wb_ack_o) begin
        wb_dat_o <= rd_mux;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // registers

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cmd_val <= 8'h00;
      ptr <= 16'h0000;
      data <= 16'h0000;
      mask <= '0;
      rd_addr <= '0;
    end else begin
      if (start) cmd_val <= nc;
      if (wr_ptr && st == H_IDLE) ptr <= (ptr & ~wmask) | (wd & wmask);
      if (wr_data && st == H_IDLE) data <= (data & ~wmask) | (wd & wmask);
      if (wr_mask) mask <= nc[ST_W-1:0];
      if (wr_rda) rd_addr <= PC_W'((rd_addr & ~wmask[PC_W-1:0]) | (wd[PC_W-1:0] & wmask[PC_W-1:0]));
    end
  end

  // write one to clear; a new event in the same cycle wins
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      status <= '0;
    end else begin
      status <= (status & ~(wr_stat ? nc[ST_W-1:0] : '0)) | ev;
    end
  end

  assign irq_o = |(status & mask);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rd_go <= 1'b0;
      rd_res <= 16'h0000;
      rd_blk <= 1'b0;
    end else begin
      rd_go <= wr_rda;
      if (link.rd_valid) begin
        rd_res <= link.rd_data;
        rd_blk <= link.rd_blocked;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // command handshake

  // write and store issue back to back, so nothing can slip between them
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st <= H_IDLE;
    end else begin
      case (st)
        H_IDLE: if (start) st <= H_POLL;
        H_POLL: if (!dev_en) st <= H_EE;
        H_EE: if (!link.ee_busy) st <= H_CTL;
        H_CTL: st <= H_STORE;
        H_STORE: st <= H_DONE;
        H_DONE: if (!dev_en) st <= H_CHECK;
        H_CHECK: st <= done_ev ? H_IDLE : H_POLL;
        default: st <= H_IDLE;
      endcase
    end
  end

  assign link.ctl_wr = (st == H_CTL);
  assign link.store = (st == H_STORE);
  assign link.ctl_wdata = cmd_val;
  assign link.ptr = ptr;
  assign link.data_word = data;
  assign link.rd_en = rd_go;
  assign link.rd_addr = rd_addr;

endmodule : fspa_host

// >>> fspa_monitor.sv
/*
  Checker of the command and read link between controller and sequencer.
  Assumes instantiation beside the link, fed with clk_i and rst_i.
*/
`timescale 1ns/10ps
module fspa_monitor (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ctl_wr,
  input wire logic [7:0] ctl_wdata,
  input wire logic [7:0] ctl_rdata,
  input wire logic store,
  input wire logic [fspa_pkg::PTR_W-1:0] ptr,
  input wire logic rd_en,
  input wire logic [fspa_pkg::PC_W-1:0] rd_addr,
  input wire logic rd_valid,
  input wire logic rd_blocked,
  input wire logic [15:0] rd_data,
  input wire logic [fspa_pkg::PC_W-1:0] boot_start
);
  import fspa_pkg::*;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  wire en_w = ctl_rdata[CTL_EN];
  wire erase_w = ctl_rdata[CTL_ERASE];
  wire write_w = ctl_rdata[CTL_WRITE];
  wire busy_w = ctl_rdata[CTL_BUSY];
  wire reen_store_w = store && ctl_rdata[CTL_REEN];
  //////////////////////////////////////////////////////////////////////
  AST_BOOT_LEGAL: assert property (boot_start inside {15'h7e00, 15'h7c00, 15'h7800, 15'h7000})
    else $error("boot start off the four sections");
  AST_PTR_BYTE: assert property (store |-> !ptr[PTR_BYTE_SEL])
    else $error("store with byte select set");
  AST_WRITE_SLOT: assert property (store && write_w && !erase_w |-> ptr[7:1] == 7'h00)
    else $error("page write with slot bits set");
  AST_POLL_EN: assert property (ctl_wr |-> !en_w)
    else $error("control write while enable still set");
  AST_STORE_WIN: assert property (ctl_wr && ctl_wdata[CTL_EN] |-> ##[1:4] store)
    else $error("store missed its window");
  AST_SHORT_DONE: assert property (store && en_w && !erase_w && !write_w |=> !en_w)
    else $error("enable not cleared after fill or re-enable");
  AST_LONG_BUSY: assert property (store && en_w && (erase_w || write_w) |=> busy_w && en_w)
    else $error("busy flag or enable missing after erase or write");
  AST_BUSY_HOLD: assert property ($fell(busy_w) |-> $past(reen_store_w))
    else $error("busy flag dropped without re-enable");
  AST_RD_BLOCK: assert property (rd_en && busy_w && rd_addr <= BLOCKED_END
    |=> rd_valid && rd_blocked && rd_data == 16'h0000)
    else $error("blocked region answered while busy");
  AST_RD_OPEN: assert property (rd_en && rd_addr >= READABLE_START |=> rd_valid && !rd_blocked)
    else $error("readable region refused");
  cover property (store && erase_w);
  cover property (store && write_w);
  cover property (rd_en && busy_w);
  cover property ($fell(busy_w));
endmodule : fspa_monitor

// >>> tb.sv
/*
  Self-checking bench: both ends joined by the link, a flash array model,
  Wishbone master tasks.
  Assumes the sequencer built with a short operation time.
*/
`timescale 1ns/10ps
module tb;
  import fspa_pkg::*;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic wb_cyc_i = 1'b0;
  logic wb_stb_i = 1'b0;
  logic wb_we_i = 1'b0;
  logic [7:0] wb_adr_i = 8'h00;
  logic [31:0] wb_dat_i = 32'h0;
  logic [3:0] wb_sel_i = 4'h0;
  logic [31:0] wb_dat_o;
  logic wb_ack_o;
  logic irq_o;
  logic [1:0] boot_size_i = 2'h0;
  logic ee_busy_i = 1'b0;
  logic fl_erase_o;
  logic fl_wr_o;
  logic [7:0] fl_page_o;
  logic [6:0] fl_word_o;
  logic [15:0] fl_wdata_o;
  logic [15:0] fl_rdata_i;
  logic [14:0] fl_raddr_o;
  logic [15:0] flash [0:32767];
  logic [15:0] exp_w [0:127];
  logic [31:0] seed = 32'h20cf3e2f;
  logic [31:0] q;
  logic [31:0] mask_v = 32'h0;
  logic [7:0] pg = 8'hdf;
  int err_total = 0;
  int cmp_count = 0;
  int wr_count = 0;
  int c0;

  fspa_if u_fspa_if ();
  fspa_dev #(.OP_CYCLES(20)) u_fspa_dev (.clk_i(clk_i), .rst_i(rst_i), .link(u_fspa_if),
    .boot_size_i(boot_size_i), .ee_busy_i(ee_busy_i), .fl_erase_o(fl_erase_o),
    .fl_wr_o(fl_wr_o), .fl_page_o(fl_page_o), .fl_word_o(fl_word_o),
    .fl_wdata_o(fl_wdata_o), .fl_raddr_o(fl_raddr_o), .fl_rdata_i(fl_rdata_i));
  fspa_host u_fspa_host (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i),
    .wb_sel_i(wb_sel_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .irq_o(irq_o),
    .link(u_fspa_if));
  fspa_monitor u_fspa_monitor (.clk_i(clk_i), .rst_i(rst_i), .ctl_wr(u_fspa_if.ctl_wr),
    .ctl_wdata(u_fspa_if.ctl_wdata), .ctl_rdata(u_fspa_if.ctl_rdata),
    .store(u_fspa_if.store), .ptr(u_fspa_if.ptr), .rd_en(u_fspa_if.rd_en),
    .rd_addr(u_fspa_if.rd_addr), .rd_valid(u_fspa_if.rd_valid),
    .rd_blocked(u_fspa_if.rd_blocked), .rd_data(u_fspa_if.rd_data),
    .boot_start(u_fspa_if.boot_start));

  always #25 clk_i = ~clk_i;
  //////////////////////////////////////////////////////////////////////
  // array model: answers at once, one word per cycle while writing
  assign fl_rdata_i = flash[fl_raddr_o];
  always @(posedge clk_i) begin
    if (fl_wr_o) begin
      flash[{fl_page_o, fl_word_o}] <= fl_wdata_o;
      wr_count <= wr_count + 1;
    end
    if (fl_erase_o) begin
      for (int k = 0; k < PAGE_WORDS; k++) begin
        flash[{fl_page_o, k[6:0]}] <= 16'hffff;
      end
    end
  end
  //////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction : xs

  function automatic logic [15:0] init_val(input logic [14:0] a);
    return {1'b0, a} ^ 16'h3c3c;
  endfunction : init_val

  function automatic logic [14:0] boot_exp(input logic [1:0] f);
    case (f)
      2'h3: return 15'h7e00;
      2'h2: return 15'h7c00;
      2'h1: return 15'h7800;
      default: return 15'h7000;
    endcase
  endfunction : boot_exp

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check

  task automatic summarize();
    if (err_total == 0 && cmp_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : summarize

  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_dat_i <= d;
    wb_sel_i <= 4'hf;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 50);
    if (n >= 50) begin
      err_total++;
    end
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask : wb

  task automatic poll(input logic [31:0] want);
    int n;
    n = 0;
    do begin
      wb(1'b0, REG_STATUS, 32'h0);
      n++;
    end while ((q & want) == 32'h0 && n < 400);
  endtask : poll

  // ee set holds the eeprom busy for a while: nothing may complete meanwhile
  task automatic cmd(input logic [15:0] p, input logic [15:0] d, input logic [7:0] c,
                     input logic [31:0] st, input logic ee);
    ee_busy_i <= ee;
    wb(1'b1, REG_PTR, {16'h0, p});
    wb(1'b1, REG_DATA, {16'h0, d});
    wb(1'b1, REG_CMD, {24'h0, c});
    if (ee) begin
      repeat (12) @(posedge clk_i);
      wb(1'b0, REG_STATUS, 32'h0);
      check(q, 32'h0);
      ee_busy_i <= 1'b0;
    end
    poll(32'h3);
    check(q, st);
    check({31'h0, irq_o}, {31'h0, |(st & mask_v)});
    wb(1'b1, REG_STATUS, 32'h7);
  endtask : cmd

  task automatic rd(input logic [14:0] a, input logic [16:0] e);
    wb(1'b1, REG_RDADDR, {17'h0, a});
    poll(32'h4);
    wb(1'b0, REG_RDDATA, 32'h0);
    check({15'h0, q[16:0]}, {15'h0, e});
    wb(1'b1, REG_STATUS, 32'h4);
  endtask : rd
  //////////////////////////////////////////////////////////////////////
  initial begin
    repeat (60000) @(posedge clk_i);
    err_total++;
    summarize();
  end

  initial begin
    for (int i = 0; i < 32768; i++) begin
      flash[i] = init_val(i[14:0]);
    end
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    for (int f = 0; f < 4; f++) begin
      boot_size_i <= f[1:0];
      repeat (3) @(posedge clk_i);
      wb(1'b0, REG_BOOT, 32'h0);
      check({17'h0, q[14:0]}, {17'h0, boot_exp(f[1:0])});
    end
    wb(1'b0, 8'h20, 32'h0);
    check(q, 32'h0);
    mask_v = 32'h1;
    wb(1'b1, REG_MASK, mask_v);
    cmd({pg, 8'h00}, 16'h0, 8'h03, 32'h1, 1'b0);
    check({16'h0, flash[{pg, 7'h7f}]}, 32'hffff);
    rd({pg, 7'h7f}, 17'h10000);
    rd(15'h7000, {1'b0, init_val(15'h7000)});
    cmd({pg, 8'h00}, 16'h0, 8'h11, 32'h1, 1'b0);
    rd({pg, 7'h7f}, 17'h0ffff);
    for (int w = 0; w < PAGE_WORDS; w++) begin
      seed = xs(seed);
      exp_w[w] = (w == 0) ? 16'h0000 : seed[15:0];
      cmd({pg, w[6:0], 1'b0}, exp_w[w], 8'h01, 32'h1, w == 1);
    end
    cmd({pg, 8'h02}, 16'h0, 8'h05, 32'h2, 1'b0);
    cmd({pg, 8'h01}, 16'h0, 8'h01, 32'h2, 1'b0);
    c0 = wr_count;
    cmd({pg, 8'h00}, 16'h0, 8'h05, 32'h1, 1'b0);
    check(32'(wr_count - c0), 32'd128);
    for (int w = 0; w < PAGE_WORDS; w++) begin
      check({16'h0, flash[{pg, w[6:0]}]}, {16'h0, exp_w[w]});
    end
    mask_v = 32'h0;
    wb(1'b1, REG_MASK, mask_v);
    cmd({pg, 8'h00}, 16'h0, 8'h11, 32'h1, 1'b0);
    rd({pg, 7'h7f}, {1'b0, exp_w[127]});
    summarize();
  end
endmodule : tb
